// >>> core/pic_pkg.sv
// Package for the prioritized interrupt controller
`default_nettype none
package pic_pkg;
  localparam int PIC_NUM_SLOTS = 40;
  localparam int PIC_SLOT_SWI = 1;
  localparam int PIC_SLOT_WDT = 2;
  localparam int PIC_SLOT_EXT0 = 3;
  localparam int PIC_SLOT_FIRST = 2;
  localparam logic [39:0] PIC_RESERVED_MASK = 40'h00_0000_4093;
  localparam logic [39:0] PIC_NMI_MASK = 40'h00_0000_0006;
  localparam logic [19:0] PIC_VEC_SWI = 20'hffff8;
  localparam logic [19:0] PIC_VEC_LOW_BASE = 20'hffffc;
  localparam logic [19:0] PIC_VEC_HIGH_BASE = 20'hfff3c;
  localparam int PIC_HIGH_FIRST = 32;
  localparam logic [11:0] PIC_ADDR_LATCH_LO = 12'h000;
  localparam logic [11:0] PIC_ADDR_LATCH_HI = 12'h004;
  localparam logic [11:0] PIC_ADDR_ENABLE_LO = 12'h008;
  localparam logic [11:0] PIC_ADDR_ENABLE_HI = 12'h00c;
  localparam logic [11:0] PIC_ADDR_CONTROL = 12'h010;
  localparam logic [11:0] PIC_ADDR_VECTOR = 12'h014;
  localparam int PIC_CTL_MIE_BIT = 0;
  localparam int PIC_CTL_EXT0EN_BIT = 1;
  localparam int PIC_CTL_WDSEL_BIT = 2;
  localparam logic PIC_WDSEL_RESET = 1'b1;
  localparam logic [2:0] PIC_CTL_RESET = 3'h4;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pic_apb_req_s;

  typedef struct packed {
    logic valid;
    logic [5:0] slot;
    logic [19:0] vector;
  } pic_grant_s;

  function automatic logic [19:0] pic_vector_of(input logic [5:0] slot);
    logic [19:0] v;
    v = 20'h00000;
    if (slot >= 6'(PIC_HIGH_FIRST)) begin
      v = PIC_VEC_HIGH_BASE - {12'h000, 6'(slot - 6'(PIC_HIGH_FIRST)), 2'b00};
    end else begin
      v = PIC_VEC_LOW_BASE - {12'h000, slot, 2'b00};
    end
    return v;
  endfunction
endpackage
`default_nettype wire

// >>> core/pic_arbiter.sv
// Fixed-priority pick of the lowest pending slot number
`default_nettype none
module pic_arbiter
  import pic_pkg::*;
#(
  parameter int N = 40
) (
  input wire logic [N-1:0] eligible,
  output pic_grant_s grant
);
  always_comb begin
    grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        grant.valid = 1'b1;
        grant.slot = 6'(i);
        grant.vector = pic_vector_of(6'(i));
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/pic_apb_slave.sv
// APB slave decode and handshake for the controller registers
`default_nettype none
module pic_apb_slave
  import pic_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] rdata_mux,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_strobe,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data
);
  logic mapped;
  assign mapped = (paddr <= PIC_ADDR_VECTOR) && (paddr[1:0] == 2'b00);
  assign wr_strobe = psel && penable && pready && pwrite && mapped;
  assign wr_addr = paddr;
  assign wr_data = pwdata;

  // Every access answers one cycle after setup
  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite && mapped) ? rdata_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// >>> core/pic_top.sv
// Prioritized interrupt controller with APB registers and CPU vector port
//
// Behaviour
// - Thirty-six sources, nestable by priority
// - Trap and watchdog unmaskable; trap unlatched
// - Request pulse sets own latch
// - Maskable needs master and own enable
// - Lowest pending slot number wins
// - Unmaskable sources taken in slot order, trap first
// - Watchdog latch 2, vector ffff4, unmaskable
// - Ext0 also needs its pin enable
// - Slots 4..31 vectors step four
// - Time base at slot 6
// - Motor channel pairs slots 8..25
// - External 5, 2, 4 at 15,29,31
// - Counters at 26..28 and 35..37
// - Slots 32..39 vectors from fff3c
// - Watchdog routes to reset until cleared
// - Acceptance clears the source latch
// - Acceptance stacks and clears master enable
// - Return instruction sets master enable
// - Latches readable, write zero clears
//
// The implementer's own choices: the APB interface to the registers and the address map.
`default_nettype none
module pic_top
  import pic_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [39:0] source_request,
  input wire logic software_trap_request,
  input wire logic watchdog_request,
  input wire logic maskable_return_instr,
  input wire logic vector_ack,
  output logic irq_valid,
  output logic [19:0] irq_vector,
  output logic [5:0] irq_slot,
  output logic stacked_master_enable,
  output logic watchdog_reset_request
);
  logic [39:0] request_latch_r;
  logic [39:0] source_enable_flag_r;
  logic master_irq_enable_r;
  logic ext0_pin_enable_r;
  logic watchdog_output_select_r;
  logic trap_pending_r;
  logic busy_r;
  logic [39:0] set_vec;
  logic [39:0] eligible;
  logic [39:0] maskable_ok;
  logic [39:0] clear_by_sw;
  logic [39:0] clear_by_accept;
  logic [31:0] rdata_mux;
  logic wr_strobe;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic accept;
  logic [5:0] win_slot;
  logic [19:0] win_vector;
  pic_grant_s grant;

  // Register write hit on one address
  function automatic logic reg_hit(input logic s, input logic [11:0] a, input logic [11:0] w);
    return s && (a == w);
  endfunction

  pic_apb_slave u_apb (
    .clock(clock),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rdata_mux(rdata_mux),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_strobe(wr_strobe),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  always_comb begin
    set_vec = source_request & ~PIC_RESERVED_MASK & ~PIC_NMI_MASK;
    set_vec[PIC_SLOT_WDT] = watchdog_request && !watchdog_output_select_r;
  end

  always_comb begin
    clear_by_sw = '0;
    if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_LATCH_LO)) begin
      clear_by_sw[31:0] = ~wr_data;
    end
    if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_LATCH_HI)) begin
      clear_by_sw[39:32] = ~wr_data[7:0];
    end
  end

  always_comb begin
    clear_by_accept = '0;
    if (accept && grant.slot >= 6'(PIC_SLOT_FIRST)) begin
      clear_by_accept[grant.slot] = 1'b1;
    end
  end

  // Request set wins over any clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      request_latch_r <= '0;
    end else begin
      request_latch_r <= ((request_latch_r & ~clear_by_sw & ~clear_by_accept) | set_vec)
                         & ~PIC_RESERVED_MASK & ~40'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      source_enable_flag_r <= '0;
    end else if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_ENABLE_LO)) begin
      source_enable_flag_r[31:0] <= wr_data & ~PIC_RESERVED_MASK[31:0];
    end else if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_ENABLE_HI)) begin
      source_enable_flag_r[39:32] <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ext0_pin_enable_r <= PIC_CTL_RESET[PIC_CTL_EXT0EN_BIT];
      watchdog_output_select_r <= PIC_CTL_RESET[PIC_CTL_WDSEL_BIT];
    end else if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_CONTROL)) begin
      ext0_pin_enable_r <= wr_data[PIC_CTL_EXT0EN_BIT];
      watchdog_output_select_r <= wr_data[PIC_CTL_WDSEL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      master_irq_enable_r <= PIC_CTL_RESET[PIC_CTL_MIE_BIT];
    end else if (accept) begin
      master_irq_enable_r <= 1'b0;
    end else if (maskable_return_instr) begin
      master_irq_enable_r <= 1'b1;
    end else if (reg_hit(wr_strobe, wr_addr, PIC_ADDR_CONTROL)) begin
      master_irq_enable_r <= wr_data[PIC_CTL_MIE_BIT];
    end
  end

  // software trap has no latch, held here only
  always_ff @(posedge clock) begin
    if (reset) begin
      trap_pending_r <= 1'b0;
    end else if (software_trap_request) begin
      trap_pending_r <= 1'b1;
    end else if (accept && grant.slot == 6'(PIC_SLOT_SWI)) begin
      trap_pending_r <= 1'b0;
    end
  end

  always_comb begin
    maskable_ok = source_enable_flag_r & {40{master_irq_enable_r}} & ~PIC_RESERVED_MASK;
    maskable_ok[PIC_SLOT_EXT0] = maskable_ok[PIC_SLOT_EXT0] && ext0_pin_enable_r;
  end

  always_comb begin
    eligible = request_latch_r & (maskable_ok | PIC_NMI_MASK);
    eligible[PIC_SLOT_SWI] = trap_pending_r;
  end

  // unmaskable pair taken in slot order only
  pic_arbiter #(
    .N(PIC_NUM_SLOTS)
  ) u_arb (
    .eligible(eligible),
    .grant(grant)
  );

  assign accept = grant.valid && !busy_r;
  assign win_slot = grant.slot;
  assign win_vector = grant.vector;

  always_ff @(posedge clock) begin
    if (reset) begin
      busy_r <= 1'b0;
      irq_valid <= 1'b0;
      irq_vector <= 20'h00000;
      irq_slot <= 6'h00;
      stacked_master_enable <= 1'b0;
    end else if (accept) begin
      busy_r <= 1'b1;
      irq_valid <= 1'b1;
      irq_vector <= win_vector;
      irq_slot <= win_slot;
      stacked_master_enable <= master_irq_enable_r;
    end else if (busy_r && vector_ack) begin
      busy_r <= 1'b0;
      irq_valid <= 1'b0;
    end
  end

  // overflow routed to reset while select set
  always_ff @(posedge clock) begin
    if (reset) begin
      watchdog_reset_request <= 1'b0;
    end else begin
      watchdog_reset_request <= watchdog_request && watchdog_output_select_r;
    end
  end

  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (paddr)
      PIC_ADDR_LATCH_LO: rdata_mux = request_latch_r[31:0];
      PIC_ADDR_LATCH_HI: rdata_mux = {24'h000000, request_latch_r[39:32]};
      PIC_ADDR_ENABLE_LO: rdata_mux = source_enable_flag_r[31:0];
      PIC_ADDR_ENABLE_HI: rdata_mux = {24'h000000, source_enable_flag_r[39:32]};
      PIC_ADDR_CONTROL: begin
        rdata_mux = {29'h0, watchdog_output_select_r, ext0_pin_enable_r, master_irq_enable_r};
      end
      PIC_ADDR_VECTOR: rdata_mux = {5'h00, irq_valid, irq_slot, irq_vector};
      default: rdata_mux = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/pic_top_props.sv
// Port assertions for the interrupt controller
`default_nettype none
module pic_top_props
  import pic_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic software_trap_request,
  input wire logic vector_ack,
  input wire logic irq_valid,
  input wire logic [19:0] irq_vector,
  input wire logic [5:0] irq_slot
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_vector_hold: assert property (
    irq_valid && !vector_ack |=> irq_valid && $stable({irq_slot, irq_vector}))
    else $error("vector not held");
  a_ack_release: assert property (irq_valid && vector_ack |=> !irq_valid)
    else $error("valid kept after ack");
  a_trap_vector: assert property (
    irq_valid && irq_slot == 6'd1 |-> irq_vector == 20'hffff8)
    else $error("bad trap vector");
  a_wdt_vector: assert property (
    irq_valid && irq_slot == 6'd2 |-> irq_vector == 20'hffff4)
    else $error("bad watchdog vector");
  a_low_vector: assert property (
    irq_valid && irq_slot > 6'd2 && irq_slot < 6'd32
    |-> irq_vector == 20'hffffc - {12'h000, irq_slot, 2'b00})
    else $error("bad low vector");
  a_high_vector: assert property (
    irq_valid && irq_slot >= 6'd32
    |-> irq_vector == 20'hfff3c - {12'h000, irq_slot - 6'd32, 2'b00})
    else $error("bad high vector");
  a_no_reserved: assert property (
    irq_valid |-> !(irq_slot inside {6'd0, 6'd4, 6'd7, 6'd14}) && irq_slot < 6'd40)
    else $error("reserved slot granted");
  a_trap_taken: assert property (
    software_trap_request && !irq_valid |-> ##[1:3] irq_valid)
    else $error("trap not taken");
  c_ack: cover property (irq_valid && vector_ack);
  c_high: cover property (irq_valid && irq_slot >= 6'd32);
  c_trap: cover property (irq_valid && irq_slot == 6'd1);
endmodule
`default_nettype wire

// >>> tb/pic_cpu_model.sv
// Behavioural CPU core that fetches the vector after a set wait
`default_nettype none
module pic_cpu_model
  import pic_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic irq_valid,
  input wire logic [3:0] ack_wait,
  output logic vector_ack
);
  logic [3:0] wait_r;
  always_ff @(posedge clock) begin
    if (reset || !irq_valid || vector_ack) begin
      vector_ack <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      vector_ack <= (wait_r == ack_wait);
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_prioritized_interrupt_controller.sv
// Self-checking bench for the prioritized interrupt controller
`default_nettype none
module tb_prioritized_interrupt_controller
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [39:0] source_request = 40'h0;
  logic [2:0] ctl = 3'h0;
  logic [3:0] ack_wait = 4'h0;
  logic pready, pslverr, vector_ack, irq_valid, stacked_master_enable, watchdog_reset_request;
  logic [19:0] irq_vector;
  logic [5:0] irq_slot;
  int miscompares = 0, checks_done = 0;
  always #5 clock = ~clock;
  pic_top DUT (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .source_request, .software_trap_request(ctl[2]), .watchdog_request(ctl[1]),
    .maskable_return_instr(ctl[0]), .vector_ack, .irq_valid, .irq_vector, .irq_slot,
    .stacked_master_enable, .watchdog_reset_request);
  pic_cpu_model cpu (.clock, .reset, .irq_valid, .ack_wait, .vector_ack);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse(input logic [39:0] s, input logic [2:0] c);
    @(posedge clock);
    source_request <= s;
    ctl <= c;
    @(posedge clock);
    source_request <= 40'h0;
    ctl <= 3'h0;
  endtask
  task automatic expect_irq(input logic [5:0] s, input logic [19:0] v);
    int n;
    for (n = 0; n < 32 && irq_valid !== 1'b1; n++) @(posedge clock);
    check({5'h0, irq_valid, irq_slot, irq_vector}, {5'h0, 1'b1, s, v});
    for (n = 0; n < 32 && irq_valid !== 1'b0; n++) @(posedge clock);
    check({31'h0, irq_valid}, 32'h0);
  endtask
  task automatic idle;
    repeat (6) @(posedge clock);
    check({31'h0, irq_valid}, 32'h0);
  endtask
  task automatic t_reset;
    rchk(PIC_ADDR_CONTROL, 32'h4);
    rchk(PIC_ADDR_LATCH_LO, 32'h0);
    rchk(PIC_ADDR_ENABLE_HI, 32'h0);
    rchk(12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    pulse(40'h0, 3'b010);
    @(posedge clock);
    check({31'h0, watchdog_reset_request}, 32'h1);
    idle;
    $display("Test reset done");
  endtask
  task automatic t_mask;
    apb(1'b1, PIC_ADDR_ENABLE_LO, 32'h20);
    pulse(40'h20, 3'b000);
    idle;
    rchk(PIC_ADDR_LATCH_LO, 32'h20);
    apb(1'b1, PIC_ADDR_LATCH_LO, 32'hffffffdf);
    rchk(PIC_ADDR_LATCH_LO, 32'h0);
    $display("Test mask done");
  endtask
  task automatic t_prio;
    ack_wait <= 4'h3;
    apb(1'b1, PIC_ADDR_ENABLE_LO, 32'h0);
    apb(1'b1, PIC_ADDR_CONTROL, 32'h1);
    pulse(40'h02_0000_0120, 3'b000);
    idle;
    apb(1'b1, PIC_ADDR_ENABLE_LO, 32'h120);
    expect_irq(6'd5, 20'hfffe8);
    check({31'h0, stacked_master_enable}, 32'h1);
    rchk(PIC_ADDR_CONTROL, 32'h0);
    rchk(PIC_ADDR_LATCH_LO, 32'h100);
    apb(1'b1, PIC_ADDR_ENABLE_HI, 32'h2);
    pulse(40'h0, 3'b001);
    expect_irq(6'd8, 20'hfffdc);
    pulse(40'h0, 3'b001);
    expect_irq(6'd33, 20'hfff38);
    $display("Test priority done");
  endtask
  task automatic t_ext0;
    ack_wait <= 4'h0;
    apb(1'b1, PIC_ADDR_ENABLE_LO, 32'h8);
    apb(1'b1, PIC_ADDR_CONTROL, 32'h1);
    pulse(40'h8, 3'b000);
    idle;
    apb(1'b1, PIC_ADDR_CONTROL, 32'h3);
    expect_irq(6'd3, 20'hffff0);
    apb(1'b1, PIC_ADDR_CONTROL, 32'h0);
    pulse(40'h0, 3'b110);
    expect_irq(6'd1, 20'hffff8);
    expect_irq(6'd2, 20'hffff4);
    $display("Test external and trap done");
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_mask;
    t_prio;
    t_ext0;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict;
  end
endmodule
bind pic_top pic_top_props u_props (.clock, .reset, .psel, .penable, .pready,
  .software_trap_request, .vector_ack, .irq_valid, .irq_vector, .irq_slot);
`default_nettype wire
